// [hw/pss_defs.vh]
// Constants for the per-port statistics event selection block
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

// Bus geometry
`define PSS_ADDR_W        20
`define PSS_NPORTS        16

// Address map: page in addr[19:12], port in addr[11:8], word in addr[7:0]
`define PSS_BLOCK_PAGE    8'h13
`define PSS_CTR45_OFS     8'h28
`define PSS_CTR23_OFS     8'h24
`define PSS_CTR45_BASE    20'h13028
`define PSS_CTR23_BASE    20'h13024
`define PSS_PORT_STRIDE   20'h00100

// Writable bits; everything else is reserved and reads zero
`define PSS_CTR45_WMASK   32'he08fe08f
`define PSS_CTR23_WMASK   32'he08f0000
`define PSS_CTR_RESET     32'h00000000

// Field positions (counter 3 shares the counter 5 layout)
`define PSS_CTR4_PRI_LSB  0
`define PSS_CTR4_DIR_BIT  7
`define PSS_CTR4_TYPE_LSB 13
`define PSS_CTR5_PRI_LSB  16
`define PSS_CTR5_DIR_BIT  23
`define PSS_CTR5_TYPE_LSB 29
`define PSS_CTR3_PRI_LSB  16
`define PSS_CTR3_DIR_BIT  23
`define PSS_CTR3_TYPE_LSB 29

// Event type codes; also the index into each event strobe vector
`define PSS_EV_UC_REQ     3'h0
`define PSS_EV_UC_ALL     3'h1
`define PSS_EV_RETRY_SYM  3'h2
`define PSS_EV_OTHER_SYM  3'h3
`define PSS_EV_UC_WORD    3'h4
`define PSS_EV_MC_PKT     3'h5
`define PSS_EV_MC_SYM     3'h6
`define PSS_EV_MC_WORD    3'h7

// Bus responses
`define PSS_RESP_OKAY     2'h0
`define PSS_RESP_SLVERR   2'h2

`endif

// [hw/pss_event_select.v]
// Event qualifier for one statistics counter of one port
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"

module pss_event_select (
  // Event strobes per direction, indexed by type code
  input  wire [7:0] rx_event_in,
  input  wire [7:0] tx_event_in,
  input  wire [1:0] rx_pri_in,
  input  wire [1:0] tx_pri_in,
  input  wire       rx_retried_in,
  input  wire       tx_retried_in,
  // Counter configuration
  input  wire [3:0] pri_select_in,
  input  wire       direction_in,
  input  wire [2:0] event_type_in,
  // Qualified count request
  output wire       hit_out
);

  // Packet and data-word types: priority applies, retries are kept
  function is_packet_type;
    input [2:0] t;
    begin
      is_packet_type = (t == `PSS_EV_UC_REQ) || (t == `PSS_EV_UC_ALL) ||
                       (t == `PSS_EV_UC_WORD) || (t == `PSS_EV_MC_PKT) ||
                       (t == `PSS_EV_MC_WORD);
    end
  endfunction

  wire [7:0] ev_sel;
  wire [1:0] pri_sel;
  wire       retried_sel;
  wire       enabled;
  wire       pri_ok;
  wire       retry_ok;
  wire       pkt_type;

  // Direction picks receive or transmit side
  assign ev_sel      = direction_in ? tx_event_in : rx_event_in;      // see [R4] [R12]
  assign pri_sel     = direction_in ? tx_pri_in : rx_pri_in;
  assign retried_sel = direction_in ? tx_retried_in : rx_retried_in;

  // Select bit 0 is priority 3, bit 3 is priority 0
  assign pri_ok   = pri_select_in[2'd3 - pri_sel];                    // see [R5] [R9]
  assign enabled  = |pri_select_in;                                   // see [R6] [R7] [R8]
  assign pkt_type = is_packet_type(event_type_in);
  assign retry_ok = ~retried_sel | pkt_type;                          // see [R3]

  // Symbol types ignore priority but still need the counter enabled
  assign hit_out = enabled & ev_sel[event_type_in] & retry_ok &
                   (pri_ok | ~pkt_type);                              // see [R1] [R2] [R15]

endmodule
`default_nettype wire

// [hw/pss_axil_slave.v]
// AXI4-Lite slave front end with single outstanding read and write
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"

module pss_axil_slave (
  input  wire                   clock_in,
  input  wire                   reset_in,
  // AXI4-Lite
  input  wire [`PSS_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire                   s_axi_awvalid_in,
  output wire                   s_axi_awready_out,
  input  wire [31:0]            s_axi_wdata_in,
  input  wire [3:0]             s_axi_wstrb_in,
  input  wire                   s_axi_wvalid_in,
  output wire                   s_axi_wready_out,
  output wire [1:0]             s_axi_bresp_out,
  output wire                   s_axi_bvalid_out,
  input  wire                   s_axi_bready_in,
  input  wire [`PSS_ADDR_W-1:0] s_axi_araddr_in,
  input  wire                   s_axi_arvalid_in,
  output wire                   s_axi_arready_out,
  output wire [31:0]            s_axi_rdata_out,
  output wire [1:0]             s_axi_rresp_out,
  output wire                   s_axi_rvalid_out,
  input  wire                   s_axi_rready_in,
  // Register file side
  output wire                   wr_en_out,
  output wire [`PSS_ADDR_W-1:0] wr_addr_out,
  output wire [31:0]            wr_data_out,
  output wire [3:0]             wr_strb_out,
  input  wire                   wr_ok_in,
  output wire [`PSS_ADDR_W-1:0] rd_addr_out,
  input  wire [31:0]            rd_data_in,
  input  wire                   rd_ok_in
);

  reg                   awready_q;
  reg                   wready_q;
  reg                   bvalid_q;
  reg [1:0]             bresp_q;
  reg [`PSS_ADDR_W-1:0] awaddr_q;
  reg [31:0]            wdata_q;
  reg [3:0]             wstrb_q;
  reg                   arready_q;
  reg                   rvalid_q;
  reg [1:0]             rresp_q;
  reg [31:0]            rdata_q;

  // Write fires once both halves are held and no response is pending
  assign wr_en_out   = ~awready_q & ~wready_q & ~bvalid_q;
  assign wr_addr_out = awaddr_q;
  assign wr_data_out = wdata_q;
  assign wr_strb_out = wstrb_q;
  assign rd_addr_out = s_axi_araddr_in;

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out  = wready_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rresp_out   = rresp_q;
  assign s_axi_rdata_out   = rdata_q;

  // Address and data taken in either order; readies return after response
  always @(posedge clock_in) begin
    if (reset_in) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PSS_RESP_OKAY;
      awaddr_q  <= {`PSS_ADDR_W{1'b0}};
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `PSS_RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else begin
      if (s_axi_awvalid_in && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && wready_q) begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata_in;
        wstrb_q  <= s_axi_wstrb_in;
      end
      if (wr_en_out) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok_in ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
      // Read data captured at the address handshake
      if (s_axi_arvalid_in && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_ok_in ? rd_data_in : 32'h00000000;
        rresp_q   <= rd_ok_in ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_in) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// [hw/pss_top.v]
// Per-port statistics counter event selection with register file
// What this block does
// [R1] Counter 3 type codes 000 to 011 count unicast requests, all unicast, retry and other symbols.
// [R2] Type codes 100 to 111 count unicast words, multicast packets, symbols and words.
// [R3] For types 000, 001, 100, 101 and 111 retried packets are still counted.
// [R4] Counter 3 direction bit 23 observes receive when 0 and transmit when 1.
// [R5] Counter 3 bit 19 set makes counter 3 count priority 0 packets.
// [R6] Counter 3 with all four priority bits clear counts nothing.
// [R7] Counters 4 and 5 each have own fields in one per-port register and are off with no priority.
// [R8] All four priority bits set counts packets of every priority.
// [R9] Counter 4/5 register bits 0 to 3 select priorities 3, 2, 1 and 0 of counter 4.
// [R10] The counter 4/5 register exists for sixteen ports from 0x13028 in 0x100 steps.
// [R11] Every counter 4/5 register resets to zero, so both counters start disabled.
// [R12] Counter 4 direction bit 7 observes receive when 0 and transmit when 1.
// [R13] Counter 4 type at bits 13 to 15 uses the same eight codes as counter 3.
// [R14] Counter 5 uses bits 16 to 19, 23 and 29 to 31; reserved bits read zero.
// [R15] A counter steps only for the chosen type, direction and, for packets, priority.
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"

module pss_top (
  // Clock and reset
  input  wire                         clock_in,
  input  wire                         reset_in,

  // AXI4-Lite write address and data
  input  wire [`PSS_ADDR_W-1:0]       s_axi_awaddr_in,
  input  wire                         s_axi_awvalid_in,
  output wire                         s_axi_awready_out,
  input  wire [31:0]                  s_axi_wdata_in,
  input  wire [3:0]                   s_axi_wstrb_in,
  input  wire                         s_axi_wvalid_in,
  output wire                         s_axi_wready_out,

  // AXI4-Lite write response
  output wire [1:0]                   s_axi_bresp_out,
  output wire                         s_axi_bvalid_out,
  input  wire                         s_axi_bready_in,

  // AXI4-Lite read
  input  wire [`PSS_ADDR_W-1:0]       s_axi_araddr_in,
  input  wire                         s_axi_arvalid_in,
  output wire                         s_axi_arready_out,
  output wire [31:0]                  s_axi_rdata_out,
  output wire [1:0]                   s_axi_rresp_out,
  output wire                         s_axi_rvalid_out,
  input  wire                         s_axi_rready_in,

  // Receive side events, 8 strobes per port indexed by type code
  input  wire [8*`PSS_NPORTS-1:0]     rx_event_in,
  input  wire [2*`PSS_NPORTS-1:0]     rx_pri_in,
  input  wire [`PSS_NPORTS-1:0]       rx_retried_in,

  // Transmit side events, same layout
  input  wire [8*`PSS_NPORTS-1:0]     tx_event_in,
  input  wire [2*`PSS_NPORTS-1:0]     tx_pri_in,
  input  wire [`PSS_NPORTS-1:0]       tx_retried_in,

  // Registered count-step pulses, one bit per port
  output wire [`PSS_NPORTS-1:0]       ctr3_step_out,
  output wire [`PSS_NPORTS-1:0]       ctr4_step_out,
  output wire [`PSS_NPORTS-1:0]       ctr5_step_out
);

  // Port register file: one counter 2/3 and one counter 4/5 word per port
  reg  [31:0]             ctr23_q [0:`PSS_NPORTS-1];
  reg  [31:0]             ctr45_q [0:`PSS_NPORTS-1];

  // Step pulses toward the counters
  reg  [`PSS_NPORTS-1:0]  ctr3_step_q;
  reg  [`PSS_NPORTS-1:0]  ctr4_step_q;
  reg  [`PSS_NPORTS-1:0]  ctr5_step_q;
  wire [`PSS_NPORTS-1:0]  ctr3_step_d;
  wire [`PSS_NPORTS-1:0]  ctr4_step_d;
  wire [`PSS_NPORTS-1:0]  ctr5_step_d;

  // Register access from the bus front end
  wire                    wr_en;
  wire [`PSS_ADDR_W-1:0]  wr_addr;
  wire [31:0]             wr_data;
  wire [3:0]              wr_strb;
  wire [`PSS_ADDR_W-1:0]  rd_addr;
  reg  [31:0]             rd_data;
  wire [5:0]              wr_dec;
  wire [5:0]              rd_dec;
  wire [31:0]             strb_bits;
  wire [31:0]             wr_mask;
  wire [31:0]             wr_old;

  integer                 i;

  // Address decode: {hit, is counter 4/5 word, port}
  // Shared by the read and write paths so both see the same map.
  function [5:0] pss_decode;
    input [`PSS_ADDR_W-1:0] a;
    begin
      pss_decode = 6'h00;
      if (a[19:12] == `PSS_BLOCK_PAGE) begin
        if (a[7:0] == `PSS_CTR45_OFS) begin
          pss_decode = {1'b1, 1'b1, a[11:8]};                       // see [R10]
        end else if (a[7:0] == `PSS_CTR23_OFS) begin
          pss_decode = {1'b1, 1'b0, a[11:8]};
        end
      end
    end
  endfunction

  // Bus front end; all its answers leave from its own flops
  pss_axil_slave u_bus (
    .clock_in          (clock_in),
    .reset_in          (reset_in),
    .s_axi_awaddr_in   (s_axi_awaddr_in),
    .s_axi_awvalid_in  (s_axi_awvalid_in),
    .s_axi_awready_out (s_axi_awready_out),
    .s_axi_wdata_in    (s_axi_wdata_in),
    .s_axi_wstrb_in    (s_axi_wstrb_in),
    .s_axi_wvalid_in   (s_axi_wvalid_in),
    .s_axi_wready_out  (s_axi_wready_out),
    .s_axi_bresp_out   (s_axi_bresp_out),
    .s_axi_bvalid_out  (s_axi_bvalid_out),
    .s_axi_bready_in   (s_axi_bready_in),
    .s_axi_araddr_in   (s_axi_araddr_in),
    .s_axi_arvalid_in  (s_axi_arvalid_in),
    .s_axi_arready_out (s_axi_arready_out),
    .s_axi_rdata_out   (s_axi_rdata_out),
    .s_axi_rresp_out   (s_axi_rresp_out),
    .s_axi_rvalid_out  (s_axi_rvalid_out),
    .s_axi_rready_in   (s_axi_rready_in),
    .wr_en_out         (wr_en),
    .wr_addr_out       (wr_addr),
    .wr_data_out       (wr_data),
    .wr_strb_out       (wr_strb),
    .wr_ok_in          (wr_dec[5]),
    .rd_addr_out       (rd_addr),
    .rd_data_in        (rd_data),
    .rd_ok_in          (rd_dec[5])
  );

  assign wr_dec = pss_decode(wr_addr);
  assign rd_dec = pss_decode(rd_addr);

  // Byte strobes widened to bit lanes
  assign strb_bits = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                      {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Reserved bits never take a write, so they keep reading zero
  assign wr_mask = strb_bits & (wr_dec[4] ? `PSS_CTR45_WMASK
                                          : `PSS_CTR23_WMASK);          // see [R14]
  assign wr_old  = wr_dec[4] ? ctr45_q[wr_dec[3:0]] : ctr23_q[wr_dec[3:0]];

  // Register file write; unmapped writes change nothing
  always @(posedge clock_in) begin
    if (reset_in) begin
      for (i = 0; i < `PSS_NPORTS; i = i + 1) begin
        ctr23_q[i] <= `PSS_CTR_RESET;
        ctr45_q[i] <= `PSS_CTR_RESET;                                 // see [R11]
      end
    end else if (wr_en && wr_dec[5]) begin
      if (wr_dec[4]) begin
        ctr45_q[wr_dec[3:0]] <= (wr_old & ~wr_mask) | (wr_data & wr_mask); // see [R7]
      end else begin
        ctr23_q[wr_dec[3:0]] <= (wr_old & ~wr_mask) | (wr_data & wr_mask);
      end
    end
  end

  // Read mux; stored reserved bits are always zero
  always @* begin
    rd_data = 32'h00000000;
    if (rd_dec[5]) begin
      if (rd_dec[4]) begin
        rd_data = ctr45_q[rd_dec[3:0]];
      end else begin
        rd_data = ctr23_q[rd_dec[3:0]];
      end
    end
  end

  // Three qualifiers per port; counter 3 uses the counter 2/3 word
  genvar p;
  generate
    for (p = 0; p < `PSS_NPORTS; p = p + 1) begin : g_port
      wire [31:0] c23;
      wire [31:0] c45;

      assign c23 = ctr23_q[p];
      assign c45 = ctr45_q[p];

      // Counter 3 fields
      pss_event_select u_ctr3 (
        .rx_event_in   (rx_event_in[8*p +: 8]),
        .tx_event_in   (tx_event_in[8*p +: 8]),
        .rx_pri_in     (rx_pri_in[2*p +: 2]),
        .tx_pri_in     (tx_pri_in[2*p +: 2]),
        .rx_retried_in (rx_retried_in[p]),
        .tx_retried_in (tx_retried_in[p]),
        .pri_select_in (c23[`PSS_CTR3_PRI_LSB +: 4]),                // see [R5] [R6]
        .direction_in  (c23[`PSS_CTR3_DIR_BIT]),                     // see [R4]
        .event_type_in (c23[`PSS_CTR3_TYPE_LSB +: 3]),               // see [R1] [R2]
        .hit_out       (ctr3_step_d[p])
      );

      // Counter 4 fields
      pss_event_select u_ctr4 (
        .rx_event_in   (rx_event_in[8*p +: 8]),
        .tx_event_in   (tx_event_in[8*p +: 8]),
        .rx_pri_in     (rx_pri_in[2*p +: 2]),
        .tx_pri_in     (tx_pri_in[2*p +: 2]),
        .rx_retried_in (rx_retried_in[p]),
        .tx_retried_in (tx_retried_in[p]),
        .pri_select_in (c45[`PSS_CTR4_PRI_LSB +: 4]),                // see [R9]
        .direction_in  (c45[`PSS_CTR4_DIR_BIT]),                     // see [R12]
        .event_type_in (c45[`PSS_CTR4_TYPE_LSB +: 3]),               // see [R13]
        .hit_out       (ctr4_step_d[p])
      );

      // Counter 5 fields
      pss_event_select u_ctr5 (
        .rx_event_in   (rx_event_in[8*p +: 8]),
        .tx_event_in   (tx_event_in[8*p +: 8]),
        .rx_pri_in     (rx_pri_in[2*p +: 2]),
        .tx_pri_in     (tx_pri_in[2*p +: 2]),
        .rx_retried_in (rx_retried_in[p]),
        .tx_retried_in (tx_retried_in[p]),
        .pri_select_in (c45[`PSS_CTR5_PRI_LSB +: 4]),                // see [R14]
        .direction_in  (c45[`PSS_CTR5_DIR_BIT]),                     // see [R14]
        .event_type_in (c45[`PSS_CTR5_TYPE_LSB +: 3]),               // see [R14]
        .hit_out       (ctr5_step_d[p])
      );
    end
  endgenerate

  // Step pulses registered: one cycle late, but glitch free at the counters
  always @(posedge clock_in) begin
    if (reset_in) begin
      ctr3_step_q <= {`PSS_NPORTS{1'b0}};
      ctr4_step_q <= {`PSS_NPORTS{1'b0}};
      ctr5_step_q <= {`PSS_NPORTS{1'b0}};
    end else begin
      ctr3_step_q <= ctr3_step_d;                                     // see [R15]
      ctr4_step_q <= ctr4_step_d;                                     // see [R15]
      ctr5_step_q <= ctr5_step_d;                                     // see [R15]
    end
  end

  assign ctr3_step_out = ctr3_step_q;
  assign ctr4_step_out = ctr4_step_q;
  assign ctr5_step_out = ctr5_step_q;

endmodule
`default_nettype wire

// [bench/pss_top_chk.sv]
// Port assertions for the statistics event select block
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"

module pss_top_chk (
  // Clock and reset
  input wire logic                     clock_in,
  input wire logic                     reset_in,
  // Register bus handshakes
  input wire logic                     s_axi_awvalid_in,
  input wire logic                     s_axi_awready_out,
  input wire logic                     s_axi_wvalid_in,
  input wire logic                     s_axi_wready_out,
  input wire logic [1:0]               s_axi_bresp_out,
  input wire logic                     s_axi_bvalid_out,
  input wire logic                     s_axi_bready_in,
  input wire logic                     s_axi_arvalid_in,
  input wire logic                     s_axi_arready_out,
  input wire logic [31:0]              s_axi_rdata_out,
  input wire logic                     s_axi_rvalid_out,
  input wire logic                     s_axi_rready_in,
  // Events and count steps
  input wire logic [8*`PSS_NPORTS-1:0] rx_event_in,
  input wire logic [8*`PSS_NPORTS-1:0] tx_event_in,
  input wire logic [`PSS_NPORTS-1:0]   ctr3_step_out,
  input wire logic [`PSS_NPORTS-1:0]   ctr4_step_out,
  input wire logic [`PSS_NPORTS-1:0]   ctr5_step_out
);
  // One clock domain, reset masks everything but the reset check
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  // Reset leaves steps and the write response quiet
  a_reset_quiet: assert property (disable iff (1'b0) reset_in |=>
    (ctr3_step_out | ctr4_step_out | ctr5_step_out) == '0 && !s_axi_bvalid_out)
    else $error("outputs active after reset");
  // A step always has an event strobe one cycle earlier
  a_step_cause: assert property ((ctr3_step_out | ctr4_step_out | ctr5_step_out) != '0
    |-> $past(rx_event_in | tx_event_in) != '0) else $error("step without event");
  // Register written one edge after joint handshake, answer seen at the next
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out |=> ##1 s_axi_bvalid_out && !s_axi_awready_out)
    else $error("write response late");
  a_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_b_release: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
    !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out) else $error("write not freed");
  a_busy_write: assert property (s_axi_bvalid_out |-> !s_axi_awready_out &&
    !s_axi_wready_out) else $error("write taken while busy");
  // Read answered at the next edge and held
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out && !s_axi_arready_out) else $error("read response late");
  a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data changed");
  // Bits reserved in both layouts never read back set
  a_reserved_zero: assert property (s_axi_rvalid_out |->
    (s_axi_rdata_out & 32'h1f701f70) == 32'h0) else $error("reserved bit read set");

  // Main scenarios reached; counters 4 and 5 never share a direction here
  c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_step: cover property ((ctr3_step_out | ctr4_step_out | ctr5_step_out) != '0);
endmodule

`default_nettype wire

// [bench/pss_top_tb_top.sv]
// Self-checking bench for the statistics event select block
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"

module pss_top_tb_top;
  // Clock, reset and bus drive
  logic        clock_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [19:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  // Event drive and step outputs
  logic [127:0] rx_ev = '0, tx_ev = '0;
  logic [31:0]  rx_pri = '0, tx_pri = '0;
  logic [15:0]  rx_rt = '0, tx_rt = '0;
  logic [15:0]  ctr3, ctr4, ctr5;
  int           err_count = 0, num_checks = 0;
  int           p, t, e, d, pr, rt;
  logic [31:0]  r45, r23;
  logic [47:0]  ex;

  always #12.5 clock_in = ~clock_in;

  pss_top dut (.clock_in(clock_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .rx_event_in(rx_ev),
    .rx_pri_in(rx_pri), .rx_retried_in(rx_rt), .tx_event_in(tx_ev), .tx_pri_in(tx_pri),
    .tx_retried_in(tx_rt), .ctr3_step_out(ctr3), .ctr4_step_out(ctr4), .ctr5_step_out(ctr5));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_val(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    err_count++;
    $display("wrong value at %0t: bus wait expired", $time);
    close_out();
  endtask

  // Write; ready for the answer raised once it is seen
  task automatic axi_write(input logic [19:0] a, input logic [31:0] v, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        check_val(bresp, er);
        break;
      end
      else if (bvalid)
        bready <= 1'b1;
    end
    if (n == 50)
      timed_out();
  endtask

  task automatic axi_read(input logic [19:0] a, input logic [31:0] ev, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        check_val({rresp, rdata}, {er, ev});
        break;
      end
      else if (rvalid)
        rready <= 1'b1;
    end
    if (n == 50)
      timed_out();
  endtask

  // Expected step of one counter whose fields start at sh
  function automatic logic hit(input logic [31:0] r, input int sh, input int dd, input int tt,
                               input int pp, input int rr);
    logic [3:0] ps;
    ps = r[sh+:4];
    if (ps == 4'h0 || r[sh+7] != dd[0] || r[sh+13+:3] != tt[2:0])
      return 1'b0;
    if (tt == 2 || tt == 3 || tt == 6)
      return rr == 0;
    return ps[3-pp];
  endfunction

  // One event strobe on port q, then the steps one cycle on
  task automatic fire(input int q, input int dd, input int tt, input int pp, input int rr,
                      input logic [47:0] exv);
    if (dd != 0) begin
      tx_ev[8*q+tt] <= 1'b1;
      tx_pri[2*q+:2] <= pp[1:0];
      tx_rt[q] <= rr[0];
    end
    else begin
      rx_ev[8*q+tt] <= 1'b1;
      rx_pri[2*q+:2] <= pp[1:0];
      rx_rt[q] <= rr[0];
    end
    @(posedge clock_in);
    rx_ev <= '0;
    tx_ev <= '0;
    // Step stands until this edge, so it is read before it drops
    @(posedge clock_in);
    check_val({ctr3, ctr4, ctr5}, exv);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    axi_read(20'h13028, 32'h0, 2'h0);
    axi_read(20'h13f28, 32'h0, 2'h0);
    axi_read(20'h13024, 32'h0, 2'h0);
    for (t = 0; t < 8; t++)
      fire(0, t & 1, t, 0, 0, 48'h0);
    // Reserved bits, byte strobes and unmapped places
    axi_write(20'h13228, 32'hffffffff, 4'hf, 2'h0);
    axi_read(20'h13228, 32'he08fe08f, 2'h0);
    axi_write(20'h13224, 32'hffffffff, 4'hf, 2'h0);
    axi_read(20'h13224, 32'he08f0000, 2'h0);
    axi_write(20'h13228, 32'h0, 4'hf, 2'h0);
    axi_write(20'h13228, 32'hffffffff, 4'h1, 2'h0);
    axi_read(20'h13228, 32'h0000008f, 2'h0);
    axi_write(20'h13020, 32'hffffffff, 4'hf, 2'h2);
    axi_read(20'h13020, 32'h0, 2'h2);
    axi_read(20'h14028, 32'h0, 2'h2);
    // Every port instance decoded on its own
    for (p = 0; p < 16; p++) begin
      axi_write(20'h13028 + 20'(p * 256), 32'(p * 32'h00010001), 4'hf, 2'h0);
      axi_write(20'h13024 + 20'(p * 256), 32'(p * 32'h00010000), 4'hf, 2'h0);
    end
    for (p = 0; p < 16; p++) begin
      axi_read(20'h13028 + 20'(p * 256), 32'(p * 32'h00010001), 2'h0);
      axi_read(20'h13024 + 20'(p * 256), 32'(p * 32'h00010000), 2'h0);
    end
    // Every type, direction, priority and retry mark on port 5
    for (t = 0; t < 8; t++) begin
      // Counter 4 priority mix reaches every select bit, none at t = 0
      r45 = 32'((t << 29) | ((~t & 1) << 23) | (15 << 16) | (t << 13) | ((t & 1) << 7)
                | ((t * 5) & 15));
      r23 = 32'((t << 29) | (((t >> 1) & 1) << 23) | (8 << 16));
      axi_write(20'h13528, r45, 4'hf, 2'h0);
      axi_write(20'h13524, r23, 4'hf, 2'h0);
      for (e = 0; e < 8; e++)
        for (d = 0; d < 2; d++)
          for (pr = 0; pr < 4; pr++)
            for (rt = 0; rt < 2; rt++) begin
              ex = '0;
              ex[37] = hit(r23, 16, d, e, pr, rt);
              ex[21] = hit(r45, 0, d, e, pr, rt);
              ex[5] = hit(r45, 16, d, e, pr, rt);
              fire(5, d, e, pr, rt, ex);
            end
    end
    close_out();
  end
endmodule

bind pss_top pss_top_chk u_chk (.clock_in(clock_in), .reset_in(reset_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .rx_event_in(rx_event_in), .tx_event_in(tx_event_in), .ctr3_step_out(ctr3_step_out),
  .ctr4_step_out(ctr4_step_out), .ctr5_step_out(ctr5_step_out));

`default_nettype wire
